// file: hdl/lane_test_pkg.sv
package lane_test_pkg;

   // Lane structure.
   localparam int NUM_LANES    = 16;
   localparam int OCTET_W      = 8;
   localparam int LANE_BUS_W   = NUM_LANES * OCTET_W;
   localparam int PRBS_W       = 31;

   // APB register byte offsets.
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] CFG_OFFSET    = 12'h004;
   localparam logic [11:0] STATUS_OFFSET = 12'h008;

   // Reset values.
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
   localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
   localparam logic [9:0]  FPMF_RESET    = 10'h020;

   // Test pattern selection codes.
   localparam logic [3:0] SEL_NORMAL = 4'h0;
   localparam logic [3:0] SEL_PRBS7  = 4'h1;
   localparam logic [3:0] SEL_PRBS9  = 4'h2;
   localparam logic [3:0] SEL_PRBS15 = 4'h3;
   localparam logic [3:0] SEL_PRBS23 = 4'h4;
   localparam logic [3:0] SEL_PRBS31 = 4'h5;
   localparam logic [3:0] SEL_CLOCK  = 4'h6;
   localparam logic [3:0] SEL_RAMP   = 4'h7;

   // Feedback taps: y[n] = y[n-a] xor y[n-b].
   localparam int PRBS7_TAP_A  = 6;
   localparam int PRBS7_TAP_B  = 7;
   localparam int PRBS9_TAP_A  = 5;
   localparam int PRBS9_TAP_B  = 9;
   localparam int PRBS15_TAP_A = 14;
   localparam int PRBS15_TAP_B = 15;
   localparam int PRBS23_TAP_A = 18;
   localparam int PRBS23_TAP_B = 23;
   localparam int PRBS31_TAP_A = 28;
   localparam int PRBS31_TAP_B = 31;

   // Clock pattern word: eight ones then eight zeros.
   localparam logic [15:0] CLOCK_WORD = 16'hff00;

   // Lane counts per link configuration mode.
   localparam logic [15:0] LANES_2_MASK  = 16'h0101;
   localparam logic [15:0] LANES_4_MASK  = 16'h0303;
   localparam logic [15:0] LANES_6_MASK  = 16'h0707;
   localparam logic [15:0] LANES_8_MASK  = 16'h0f0f;
   localparam logic [15:0] LANES_16_MASK = 16'hffff;

   typedef struct packed {
      logic [23:0] unused;
      logic [3:0]  test_pattern_select;
      logic        reserved;
      logic        sync_hdr_fec;
      logic        enc_64b66b;
      logic        link_enable;
   } ctrl_reg_type;

   typedef struct packed {
      logic [13:0] unused;
      logic [9:0]  frames_per_mf;
      logic [1:0]  reserved;
      logic [5:0]  link_config_mode;
   } cfg_reg_type;

endpackage

// file: hdl/serial_lane_test_pattern_gen.sv
`timescale 1ns/1ps

module serial_lane_test_pattern_gen
   import lane_test_pkg::*;
(
   // Clock and reset.
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // APB slave.
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Device pin.
   input  wire logic                  power_down_pin,
   // Link layer status.
   input  wire logic                  ila_done,
   input  wire logic                  serdes_init_done,
   // Formatter samples.
   input  wire logic [LANE_BUS_W-1:0] fmt_data,
   // Lane data towards link layer or serializer.
   output logic      [LANE_BUS_W-1:0] lane_data,
   output logic                       lane_valid,
   output logic                       link_bypass,
   output logic      [NUM_LANES-1:0]  lane_power_en,
   output logic      [NUM_LANES-1:0]  lane_driver_en,
   output logic                       sync_hdr_fec
);

   ////////////////////////////////////////////////////////////////////////
   // PRBS step: advances one generator by eight bits, first bit in bit 7.

   function automatic logic [PRBS_W+OCTET_W-1:0] prbs_step(input logic [PRBS_W-1:0] state_in,
                                                         input logic [3:0]        sel);
      logic [PRBS_W-1:0]  s;
      logic [OCTET_W-1:0] o;
      logic               b;
      s = state_in;
      o = '0;
      for (int k = 0; k < OCTET_W; k++) begin
         unique case (sel)
            SEL_PRBS7:  b = s[PRBS7_TAP_A-1] ^ s[PRBS7_TAP_B-1];
            SEL_PRBS9:  b = s[PRBS9_TAP_A-1] ^ s[PRBS9_TAP_B-1];
            SEL_PRBS15: b = s[PRBS15_TAP_A-1] ^ s[PRBS15_TAP_B-1];
            SEL_PRBS23: b = s[PRBS23_TAP_A-1] ^ s[PRBS23_TAP_B-1];
            default:    b = s[PRBS31_TAP_A-1] ^ s[PRBS31_TAP_B-1];
         endcase
         s = {s[PRBS_W-2:0], b};
         o[OCTET_W-1-k] = b;
      end
      return {s, o};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers and state.

   typedef enum logic [1:0] {
      RAMP_IDLE,
      RAMP_WAIT,
      RAMP_RUN
   } ramp_state_type;

   ctrl_reg_type          ctrl_ff;
   cfg_reg_type           cfg_ff;
   logic [31:0]           prdata_ff;
   logic                  pready_ff;
   logic                  pslverr_ff;
   logic                  pd_meta_ff;
   logic                  pd_sync_ff;
   logic [3:0]            active_sel_ff;
   ramp_state_type        ramp_state_ff;
   ramp_state_type        nxt_ramp_state;
   logic [9:0]            oct_cnt_ff;
   logic [9:0]            nxt_oct_cnt;
   logic                  clk_phase_ff;
   logic [LANE_BUS_W-1:0] lane_data_ff;
   logic [LANE_BUS_W-1:0] nxt_lane_data;
   logic                  lane_valid_ff;
   logic                  nxt_lane_valid;
   logic                  link_bypass_ff;
   logic [NUM_LANES-1:0]  lane_power_en_ff;
   logic [NUM_LANES-1:0]  lane_driver_en_ff;
   logic                  sync_hdr_fec_ff;

   ////////////////////////////////////////////////////////////////////////
   // APB decode.

   wire       apb_access = psel & penable;
   wire       apb_answer = apb_access & ~pready_ff;
   wire       apb_done   = apb_access & pready_ff;
   wire       hit_ctrl   = (paddr == CTRL_OFFSET);
   wire       hit_cfg    = (paddr == CFG_OFFSET);
   wire       hit_status = (paddr == STATUS_OFFSET);
   wire       hit_any    = hit_ctrl | hit_cfg | hit_status;
   wire       wr_ctrl    = apb_done & pwrite & hit_ctrl;
   wire       wr_cfg     = apb_done & pwrite & hit_cfg;
   wire       ramp_run   = (ramp_state_ff == RAMP_RUN);

   wire [31:0] status_word = {24'h000000, active_sel_ff, 2'h0, ramp_run, pd_sync_ff};
   wire [31:0] rd_word     = hit_ctrl ? ctrl_ff :
                             hit_cfg  ? cfg_ff  :
                             hit_status ? status_word : 32'h0000_0000;

   // Writes to the status word are ignored; only unmapped addresses fail.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff  <= apb_answer;
         prdata_ff  <= (apb_answer & ~pwrite) ? rd_word : 32'h0000_0000;
         pslverr_ff <= apb_answer & ~hit_any;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= CTRL_RESET;
         cfg_ff  <= {CFG_RESET[31:18], FPMF_RESET, CFG_RESET[7:0]};
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= {24'h000000, pwdata[7:4], 1'b0, pwdata[2:0]};
         end
         if (wr_cfg) begin
            cfg_ff <= {14'h0000, pwdata[17:8], 2'h0, pwdata[5:0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power-down pin synchroniser.

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_meta_ff <= 1'b0;
         pd_sync_ff <= 1'b0;
      end else begin
         pd_meta_ff <= power_down_pin;
         pd_sync_ff <= pd_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pattern selection is taken only while the link is down.

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_sel_ff <= SEL_NORMAL;
      end else if (!ctrl_ff.link_enable) begin
         active_sel_ff <= ctrl_ff.test_pattern_select;
      end
   end

   wire sel_prbs  = (active_sel_ff >= SEL_PRBS7) && (active_sel_ff <= SEL_PRBS31);
   wire sel_clock = (active_sel_ff == SEL_CLOCK);
   wire sel_ramp  = (active_sel_ff == SEL_RAMP);
   wire running   = ctrl_ff.link_enable & ~pd_sync_ff;

   ////////////////////////////////////////////////////////////////////////
   // Ramp sequencer.

   wire ramp_start = ctrl_ff.enc_64b66b ? serdes_init_done : ila_done;
   wire [9:0] last_oct = (cfg_ff.frames_per_mf == 10'h000) ? 10'h000 : cfg_ff.frames_per_mf - 10'h001;

   always_comb begin
      nxt_ramp_state = ramp_state_ff;
      nxt_oct_cnt    = oct_cnt_ff;
      unique case (ramp_state_ff)
         RAMP_IDLE: begin
            nxt_oct_cnt = 10'h000;
            if (running && sel_ramp) begin
               nxt_ramp_state = RAMP_WAIT;
            end
         end
         RAMP_WAIT: begin
            if (!running || !sel_ramp) begin
               nxt_ramp_state = RAMP_IDLE;
            end else if (ramp_start) begin
               nxt_ramp_state = RAMP_RUN;
            end
         end
         RAMP_RUN: begin
            if (!running || !sel_ramp) begin
               nxt_ramp_state = RAMP_IDLE;
            end else if (oct_cnt_ff >= last_oct) begin
               nxt_oct_cnt = 10'h000;
            end else begin
               nxt_oct_cnt = oct_cnt_ff + 10'h001;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_state_ff <= RAMP_IDLE;
         oct_cnt_ff    <= 10'h000;
      end else begin
         ramp_state_ff <= nxt_ramp_state;
         oct_cnt_ff    <= nxt_oct_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock pattern phase: alternates upper and lower half of the word.

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_phase_ff <= 1'b0;
      end else begin
         clk_phase_ff <= (running && sel_clock) ? ~clk_phase_ff : 1'b0;
      end
   end

   wire [OCTET_W-1:0] clock_octet = clk_phase_ff ? CLOCK_WORD[7:0] : CLOCK_WORD[15:8];

   ////////////////////////////////////////////////////////////////////////
   // Per-lane generators.

   genvar lane;
   generate
      for (lane = 0; lane < NUM_LANES; lane++) begin : g_lane
         localparam logic [PRBS_W-1:0] SEED = PRBS_W'(lane + 1);
         logic [PRBS_W-1:0]         prbs_ff;
         logic [PRBS_W+OCTET_W-1:0] step;
         logic [OCTET_W-1:0]        octet;

         assign step = prbs_step(prbs_ff, active_sel_ff);

         // Nonzero distinct seeds give each lane its own phase of the sequence.
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               prbs_ff <= SEED;
            end else if (running && sel_prbs) begin
               prbs_ff <= step[PRBS_W+OCTET_W-1:OCTET_W];
            end else begin
               prbs_ff <= SEED;
            end
         end

         assign octet = sel_prbs  ? step[OCTET_W-1:0] :
                        sel_clock ? clock_octet :
                        sel_ramp  ? oct_cnt_ff[7:0] :
                        fmt_data[lane*OCTET_W +: OCTET_W];
         assign nxt_lane_data[lane*OCTET_W +: OCTET_W] = running ? octet : '0;
      end
   endgenerate

   assign nxt_lane_valid = running & (sel_ramp ? ramp_run : 1'b1);

   ////////////////////////////////////////////////////////////////////////
   // Lane power map from link configuration mode.

   logic [NUM_LANES-1:0] mode_mask;

   always_comb begin
      unique case (cfg_ff.link_config_mode)
         6'd32, 6'd33:        mode_mask = LANES_6_MASK;
         6'd34, 6'd35, 6'd37: mode_mask = LANES_4_MASK;
         6'd38, 6'd39, 6'd56: mode_mask = LANES_2_MASK;
         6'd27:               mode_mask = LANES_16_MASK;
         default:             mode_mask = LANES_8_MASK;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Output registers.

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lane_data_ff      <= '0;
         lane_valid_ff     <= 1'b0;
         link_bypass_ff    <= 1'b0;
         lane_power_en_ff  <= '0;
         lane_driver_en_ff <= '0;
         sync_hdr_fec_ff   <= 1'b0;
      end else begin
         lane_data_ff      <= nxt_lane_data;
         lane_valid_ff     <= nxt_lane_valid;
         link_bypass_ff    <= sel_prbs | sel_clock;
         lane_power_en_ff  <= mode_mask;
         lane_driver_en_ff <= pd_sync_ff ? '0 : mode_mask;
         sync_hdr_fec_ff   <= ctrl_ff.sync_hdr_fec;
      end
   end

   assign prdata         = prdata_ff;
   assign pready         = pready_ff;
   assign pslverr        = pslverr_ff;
   assign lane_data      = lane_data_ff;
   assign lane_valid     = lane_valid_ff;
   assign link_bypass    = link_bypass_ff;
   assign lane_power_en  = lane_power_en_ff;
   assign lane_driver_en = lane_driver_en_ff;
   assign sync_hdr_fec   = sync_hdr_fec_ff;

endmodule

// file: verification/lane_gen_chk.sv
`timescale 1ns/1ps
module lane_gen_chk
   import lane_test_pkg::*;
(
   // Clock and reset.
   input wire logic                  pclk,
   input wire logic                  presetn,
   // APB.
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   // Lanes.
   input wire logic                  power_down_pin,
   input wire logic [LANE_BUS_W-1:0] lane_data,
   input wire logic                  lane_valid,
   input wire logic                  link_bypass,
   input wire logic [NUM_LANES-1:0]  lane_power_en,
   input wire logic [NUM_LANES-1:0]  lane_driver_en,
   input wire logic                  sync_hdr_fec
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   apb_wait_a: assert property (psel && !penable |-> ##2 pready)
      else $error("apb answer not after one wait state");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
      else $error("read data or error outside answer");
   pd_drv_a: assert property (power_down_pin [*5] |-> lane_driver_en == '0 && !lane_valid)
      else $error("lane drivers on during power down");
   drv_mask_a: assert property ((lane_driver_en & ~lane_power_en) == '0)
      else $error("driver enabled on unpowered lane");
   ramp_same_a: assert property (lane_valid && !link_bypass |-> lane_data[7:0] == lane_data[71:64])
      else $error("encoded lanes carry different octets");
   fec_write_a: assert property ($changed(sync_hdr_fec) |-> $past(pready, 2))
      else $error("sync header mode changed without a write");
   bypass_frozen_a: assert property (lane_valid && $past(lane_valid) |-> $stable(link_bypass))
      else $error("pattern path changed while linked");

   cover property (pready && pslverr);
   cover property (lane_valid && link_bypass);
   cover property (lane_valid && !link_bypass);
endmodule

bind serial_lane_test_pattern_gen lane_gen_chk lane_gen_chk_i (.pclk, .presetn, .psel, .penable, .prdata,
   .pready, .pslverr, .power_down_pin, .lane_data, .lane_valid, .link_bypass, .lane_power_en,
   .lane_driver_en, .sync_hdr_fec);

// file: verification/lane_prbs_rx.sv
`timescale 1ns/1ps
module lane_prbs_rx (
   // Clock and reset.
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Lane octets, first bit is bit 7.
   input  wire logic       lane_valid,
   input  wire logic [7:0] octet,
   // Feedback taps.
   input  wire logic [4:0] tap_a,
   input  wire logic [4:0] tap_b,
   // Results.
   output int              bit_cnt,
   output int              err_cnt
);
   logic [30:0] hist;
   int          seen;

   // Checks each bit against earlier bits, so no starting state is assumed.
   always @(posedge pclk) begin
      if (!presetn) begin
         bit_cnt = 0;
         err_cnt = 0;
         seen = 0;
      end else if (!lane_valid) begin
         seen = 0;
      end else begin
         for (int k = 7; k >= 0; k--) begin
            if (seen >= tap_b && octet[k] !== (hist[tap_a-1] ^ hist[tap_b-1])) err_cnt++;
            hist = {hist[29:0], octet[k]};
            seen++;
            bit_cnt++;
         end
      end
   end
endmodule

// file: verification/serial_lane_test_pattern_gen_tb.sv
`timescale 1ns/1ps
module serial_lane_test_pattern_gen_tb;
   import lane_test_pkg::*;

   logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0]           paddr;
   logic [31:0]           pwdata, prdata;
   logic                  power_down_pin, ila_done, serdes_init_done, lane_valid, link_bypass, sync_hdr_fec;
   logic [LANE_BUS_W-1:0] fmt_data, lane_data;
   logic [NUM_LANES-1:0]  lane_power_en, lane_driver_en;
   logic [4:0]            tap_a, tap_b;
   int                    bit_cnt, rx_err, err_count, n_tests, nd;
   logic [7:0]            o1, o2;

   serial_lane_test_pattern_gen serial_lane_test_pattern_gen_i (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .power_down_pin, .ila_done, .serdes_init_done, .fmt_data,
      .lane_data, .lane_valid, .link_bypass, .lane_power_en, .lane_driver_en, .sync_hdr_fec);
   lane_prbs_rx lane_prbs_rx_i (.pclk, .presetn, .lane_valid, .octet(lane_data[7:0]), .tap_a, .tap_b,
      .bit_cnt, .err_cnt(rx_err));

   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task complete_run;
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask
   task hang;
      err_count++;
      complete_run;
   endtask
   // Reads compare data; every transfer compares the error flag.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] ed);
      int n;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) hang;
      if (!w) chk("prdata", ed, prdata);
      chk("pslverr", {31'h0, a > STATUS_OFFSET}, {31'h0, pslverr});
      psel <= 0;
      penable <= 0;
   endtask
   task wait_valid;
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while (lane_valid !== 1'b1 && n < 100);
      if (n >= 100) hang;
   endtask
   task run(input logic [3:0] s, input logic [3:0] f);
      apb(1, CTRL_OFFSET, {24'h0, s, f}, 0);
      apb(1, CTRL_OFFSET, {24'h0, s, f | 4'h1}, 0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   logic [5:0]  modes [4] = '{6'd27, 6'd38, 6'd34, 6'd32};
   logic [15:0] masks [4] = '{LANES_16_MASK, LANES_2_MASK, LANES_4_MASK, LANES_6_MASK};
   int          ta [5] = '{PRBS7_TAP_A, PRBS9_TAP_A, PRBS15_TAP_A, PRBS23_TAP_A, PRBS31_TAP_A};
   int          tb [5] = '{PRBS7_TAP_B, PRBS9_TAP_B, PRBS15_TAP_B, PRBS23_TAP_B, PRBS31_TAP_B};
   int          ks [2] = '{4, 300};

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, power_down_pin, ila_done, serdes_init_done} = '0;
      fmt_data = {NUM_LANES{8'h5a}};
      tap_a = 5'd6;
      tap_b = 5'd7;
      err_count = 0;
      n_tests = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1;
      apb(0, CTRL_OFFSET, CTRL_RESET, CTRL_RESET);
      apb(0, CFG_OFFSET, 0, {14'h0, FPMF_RESET, 8'h00});
      apb(0, 12'h010, 0, 32'h0);
      chk("power_en", {16'h0, LANES_8_MASK}, {16'h0, lane_power_en});
      for (int i = 0; i < 4; i++) begin
         apb(1, CFG_OFFSET, {14'h0, FPMF_RESET, 2'b00, modes[i]}, 0);
         repeat (2) @(posedge pclk);
         chk("power_en", {16'h0, masks[i]}, {16'h0, lane_power_en});
      end
      for (int k = 0; k < 5; k++) begin
         run(SEL_PRBS7 + 4'(k), 4'h0);
         tap_a <= 5'(ta[k]);
         tap_b <= 5'(tb[k]);
         wait_valid;
         nd = 0;
         repeat (60) begin
            @(posedge pclk);
            #1;
            nd += int'(lane_data[7:0] !== lane_data[15:8]);
         end
         chk("bypass", 1, {31'h0, link_bypass});
         chk("prbs_err", 0, rx_err);
         chk("phase_differs", 1, {31'h0, nd > 0});
      end
      chk("rx_bits", 1, {31'h0, bit_cnt > 2000});
      run(SEL_CLOCK, 4'h0);
      wait_valid;
      o1 = lane_data[7:0];
      @(posedge pclk);
      #1;
      o2 = lane_data[7:0];
      chk("clock_word", {16'h0, CLOCK_WORD}, {16'h0, o1 == 8'hff ? {o1, o2} : {o2, o1}});
      chk("bypass", 1, {31'h0, link_bypass});
      run(SEL_NORMAL, 4'h0);
      wait_valid;
      chk("normal", {4{8'h5a}}, lane_data[31:0]);
      chk("bypass", 0, {31'h0, link_bypass});
      for (int c = 0; c < 2; c++) begin
         apb(1, CFG_OFFSET, {14'h0, 10'(ks[c]), 8'd32}, 0);
         run(SEL_RAMP, c == 0 ? 4'h2 : 4'h0);
         repeat (10) @(posedge pclk);
         #1;
         chk("ramp_wait", 0, {31'h0, lane_valid});
         @(posedge pclk);
         if (c == 0) serdes_init_done <= 1;
         else ila_done <= 1;
         wait_valid;
         for (int i = 0; i < ks[c] + 12; i++) begin
            chk("ramp", (i % ks[c]) & 32'hff, {24'h0, lane_data[7:0]});
            @(posedge pclk);
            #1;
         end
         apb(0, STATUS_OFFSET, 0, {24'h0, SEL_RAMP, 4'h2});
         chk("bypass", 0, {31'h0, link_bypass});
         apb(1, CTRL_OFFSET, {24'h0, SEL_PRBS7, 4'h1}, 0);
         repeat (3) @(posedge pclk);
         #1;
         chk("frozen", 0, {31'h0, link_bypass});
         apb(1, CTRL_OFFSET, 32'h0, 0);
         @(posedge pclk);
         serdes_init_done <= 0;
         ila_done <= 0;
      end
      apb(1, CTRL_OFFSET, 32'h4, 0);
      @(posedge pclk);
      #1;
      chk("fec", 1, {31'h0, sync_hdr_fec});
      apb(1, CTRL_OFFSET, 32'h0, 0);
      @(posedge pclk);
      #1;
      chk("fec", 0, {31'h0, sync_hdr_fec});
      @(posedge pclk);
      power_down_pin <= 1;
      repeat (6) @(posedge pclk);
      #1;
      chk("driver_en", 0, {16'h0, lane_driver_en});
      @(posedge pclk);
      power_down_pin <= 0;
      repeat (6) @(posedge pclk);
      #1;
      chk("driver_en", {16'h0, LANES_6_MASK}, {16'h0, lane_driver_en});
      complete_run;
   end
endmodule
